// ---- rtl/strap_pkg.sv ----
package strap_pkg;

  // ----------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_BASIC_CTRL = 8'h00;
  localparam logic [7:0] IDX_ADVERT = 8'h04;
  localparam logic [7:0] IDX_STRAP_STAT = 8'h10;
  localparam logic [7:0] IDX_LAMP_CTRL = 8'h1f;
  localparam logic [7:0] ADDR_BASIC_CTRL = {IDX_BASIC_CTRL[5:0], 2'b00};
  localparam logic [7:0] ADDR_ADVERT = {IDX_ADVERT[5:0], 2'b00};
  localparam logic [7:0] ADDR_STRAP_STAT = {IDX_STRAP_STAT[5:0], 2'b00};
  localparam logic [7:0] ADDR_LAMP_CTRL = {IDX_LAMP_CTRL[5:0], 2'b00};

  localparam int REG_W = 16;
  localparam int WB_DATA_W = 32;
  localparam int WB_SEL_W = 4;
  localparam int PHY_ADDR_W = 5;

  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  localparam int BC_SOFT_RST_BIT = 15;
  localparam int BC_SPEED_BIT = 13;
  localparam int BC_ANEG_BIT = 12;
  localparam int BC_DUPLEX_BIT = 8;
  localparam logic [15:0] BC_WRITE_MASK = 16'h3100;
  localparam logic [15:0] BC_RESET = 16'h3100;

  localparam int ADV_100FD_BIT = 8;
  localparam int ADV_100HD_BIT = 7;
  localparam int ADV_10FD_BIT = 6;
  localparam int ADV_10HD_BIT = 5;
  localparam logic [4:0] ADV_SELECTOR = 5'h01;
  localparam logic [15:0] ADV_WRITE_MASK = 16'h01e0;
  localparam logic [15:0] ADV_RESET = 16'h01e1;

  localparam int LC_MODE_LO = 4;
  localparam int LC_MODE_HI = 5;
  localparam logic [1:0] LAMP_MODE_LINK_ACT = 2'h0;
  localparam logic [1:0] LAMP_MODE_LINK = 2'h1;
  localparam logic LAMP_OFF = 1'b1;
  localparam logic LAMP_ON = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int LAMP_BLINK_MS = 50;
  localparam int LAMP_BLINK_CYCLES = LAMP_BLINK_MS * 1000 * CLK_MHZ;

  typedef enum logic {CAP_SAMPLE, CAP_HOLD} cap_state_e;

endpackage

// ---- rtl/lamp_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface lamp_if;
  logic [1:0] mode;
  logic linkUp;
  logic activity;
  logic lampLevel;
  modport ctrl (output mode, output linkUp, output activity,
    input lampLevel);
  modport blink (input mode, input linkUp, input activity,
    output lampLevel);
endinterface
`default_nettype wire

// ---- rtl/lamp_blinker.sv ----
`timescale 1ns/100ps
`default_nettype none
module lamp_blinker #(
  parameter int BLINK_CYCLES = strap_pkg::LAMP_BLINK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  lamp_if.blink lamp
);
  localparam int CNT_W = $clog2(BLINK_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BLINK_CYCLES - 1);

  if (BLINK_CYCLES < 2) begin : gBad
    $error("blink period must be at least two cycles");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic phase;
    logic level;
  } blink_s;

  blink_s st_reg;
  blink_s st_next;
  logic tick;

  always_comb begin
    st_next = st_reg;
    tick = (st_reg.cnt == CNT_LAST);
    st_next.cnt = tick ? '0 : st_reg.cnt + 1'b1;
    if (tick && lamp.activity) begin
      st_next.phase = ~st_reg.phase;
    end
    case (lamp.mode)
      strap_pkg::LAMP_MODE_LINK_ACT: begin
        if (!lamp.linkUp) begin
          st_next.level = strap_pkg::LAMP_OFF;
        end else if (lamp.activity) begin
          st_next.level = st_reg.phase;
        end else begin
          st_next.level = strap_pkg::LAMP_ON;
        end
      end
      strap_pkg::LAMP_MODE_LINK: begin
        st_next.level = lamp.linkUp ? strap_pkg::LAMP_ON
                                    : strap_pkg::LAMP_OFF;
      end
      // reserved codes keep the lamp dark rather than guess
      default: begin
        st_next.level = strap_pkg::LAMP_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{cnt: '0, phase: 1'b1, level: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign lamp.lampLevel = st_reg.level;

  AST_BLINK_TOGGLE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (tick && lamp.activity) |=> (st_reg.phase != $past(st_reg.phase)))
    else $error("blink phase did not toggle on tick");

endmodule
`default_nettype wire

// ---- rtl/strap_latch_and_led_control.sv ----
`timescale 1ns/100ps
`default_nettype none
module strap_latch_and_led_control #(
  parameter int ADDR_W = 8,
  parameter int BLINK_CYCLES = strap_pkg::LAMP_BLINK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [strap_pkg::WB_SEL_W-1:0] sel_i,
  input wire logic [strap_pkg::WB_DATA_W-1:0] dat_i,
  output logic [strap_pkg::WB_DATA_W-1:0] dat_o,
  output logic ack_o,
  input wire logic linkUp,
  input wire logic activity,
  input wire logic autonegSpeedStrapIn,
  output logic statusLampOut,
  output logic statusLampOe,
  input wire logic [1:0] stationAddrStrapIn,
  input wire logic [1:0] addrPinFunc,
  output logic [1:0] stationAddrStrapOut,
  output logic [1:0] stationAddrStrapOe,
  output logic [strap_pkg::PHY_ADDR_W-1:0] phyAddr,
  output logic autonegEnable,
  output logic speedSelect100,
  output logic fullDuplex
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 8) begin : gBadAddr
    $error("address bus must reach the lamp control word");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    strap_pkg::cap_state_e state;
    logic anegStrap;
    logic [strap_pkg::PHY_ADDR_W-1:0] phyAddr;
    logic [strap_pkg::REG_W-1:0] basicCtrl;
    logic [strap_pkg::REG_W-1:0] advert;
    logic [1:0] lampMode;
    logic [1:0] pinOut;
    logic ack;
    logic [strap_pkg::WB_DATA_W-1:0] datOut;
  } ctrl_s;

  ctrl_s st_reg;
  ctrl_s st_next;
  lamp_if lampBus ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] mergeBytes(
    input logic [15:0] old,
    input logic [31:0] wdat,
    input logic [3:0] sel,
    input logic [15:0] mask
  );
    logic [15:0] upd;
    upd = old;
    if (sel[0]) begin
      upd[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      upd[15:8] = wdat[15:8];
    end
    return (upd & mask) | (old & ~mask);
  endfunction

  // strap high: autoneg on, 100 Mbps; strap low: autoneg off, 10 Mbps
  function automatic logic [15:0] basicFromStrap(input logic aneg);
    logic [15:0] v;
    v = strap_pkg::BC_RESET;
    v[strap_pkg::BC_ANEG_BIT] = aneg;
    v[strap_pkg::BC_SPEED_BIT] = aneg;
    return v;
  endfunction

  // 10 Mbps abilities always offered, 100 Mbps only with strap high
  function automatic logic [15:0] advertFromStrap(input logic aneg);
    logic [15:0] v;
    v = strap_pkg::ADV_RESET;
    v[strap_pkg::ADV_100FD_BIT] = aneg;
    v[strap_pkg::ADV_100HD_BIT] = aneg;
    return v;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic hit;
  logic wrTake;
  logic [5:0] idx;

  always_comb begin
    st_next = st_reg;
    hit = cyc_i && stb_i;
    idx = adr_i[7:2];
    // write lands on the edge where the master sees ack
    wrTake = hit && we_i && st_reg.ack;
    st_next.ack = hit && !st_reg.ack;
    st_next.pinOut = addrPinFunc;

    if (hit && !st_reg.ack) begin
      st_next.datOut = '0;
      case (idx)
        strap_pkg::IDX_BASIC_CTRL[5:0]: begin
          st_next.datOut[15:0] = st_reg.basicCtrl;
        end
        strap_pkg::IDX_ADVERT[5:0]: begin
          st_next.datOut[15:0] = st_reg.advert;
        end
        strap_pkg::IDX_STRAP_STAT[5:0]: begin
          st_next.datOut[4:0] = st_reg.phyAddr;
          st_next.datOut[5] = st_reg.anegStrap;
          st_next.datOut[6] = linkUp;
          st_next.datOut[7] = lampBus.lampLevel;
          st_next.datOut[8] = (st_reg.state == strap_pkg::CAP_HOLD);
        end
        strap_pkg::IDX_LAMP_CTRL[5:0]: begin
          st_next.datOut[strap_pkg::LC_MODE_HI:strap_pkg::LC_MODE_LO] =
            st_reg.lampMode;
        end
        default: begin
          st_next.datOut = '0;
        end
      endcase
    end

    if (wrTake) begin
      case (idx)
        strap_pkg::IDX_BASIC_CTRL[5:0]: begin
          if (sel_i[1] && dat_i[strap_pkg::BC_SOFT_RST_BIT]) begin
            // soft reset restores strapped values; straps not re-read
            st_next.basicCtrl = basicFromStrap(st_reg.anegStrap);
            st_next.advert = advertFromStrap(st_reg.anegStrap);
            st_next.lampMode = strap_pkg::LAMP_MODE_LINK_ACT;
          end else begin
            st_next.basicCtrl = mergeBytes(st_reg.basicCtrl, dat_i,
              sel_i, strap_pkg::BC_WRITE_MASK);
          end
        end
        strap_pkg::IDX_ADVERT[5:0]: begin
          st_next.advert = mergeBytes(st_reg.advert, dat_i, sel_i,
            strap_pkg::ADV_WRITE_MASK);
        end
        strap_pkg::IDX_LAMP_CTRL[5:0]: begin
          if (sel_i[0]) begin
            st_next.lampMode =
              dat_i[strap_pkg::LC_MODE_HI:strap_pkg::LC_MODE_LO];
          end
        end
        default: begin
          st_next.lampMode = st_reg.lampMode;
        end
      endcase
    end

    case (st_reg.state)
      strap_pkg::CAP_SAMPLE: begin
        // first edge after release catches the straps once
        st_next.anegStrap = autonegSpeedStrapIn;
        st_next.basicCtrl = basicFromStrap(autonegSpeedStrapIn);
        st_next.advert = advertFromStrap(autonegSpeedStrapIn);
        st_next.phyAddr = {
          2'b00,
          stationAddrStrapIn[1],
          {2{stationAddrStrapIn[0]}}
        };
        st_next.state = strap_pkg::CAP_HOLD;
      end
      strap_pkg::CAP_HOLD: begin
        st_next.state = strap_pkg::CAP_HOLD;
      end
      default: begin
        st_next.state = strap_pkg::CAP_SAMPLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{state: strap_pkg::CAP_SAMPLE, anegStrap: 1'b1,
        phyAddr: '0, basicCtrl: strap_pkg::BC_RESET,
        advert: strap_pkg::ADV_RESET,
        lampMode: strap_pkg::LAMP_MODE_LINK_ACT, pinOut: '0,
        ack: 1'b0, datOut: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign lampBus.mode = st_reg.lampMode;
  assign lampBus.linkUp = linkUp;
  assign lampBus.activity = activity;

  lamp_blinker #(
    .BLINK_CYCLES(BLINK_CYCLES)
  ) uBlinker (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .lamp(lampBus.blink)
  );

  assign dat_o = st_reg.datOut;
  assign ack_o = st_reg.ack;
  assign statusLampOut = lampBus.lampLevel;
  // pins stay released until the capture edge has passed
  assign statusLampOe = (st_reg.state == strap_pkg::CAP_HOLD);
  assign stationAddrStrapOe =
    {2{st_reg.state == strap_pkg::CAP_HOLD}};
  assign stationAddrStrapOut = st_reg.pinOut;
  assign phyAddr = st_reg.phyAddr;
  assign autonegEnable = st_reg.basicCtrl[strap_pkg::BC_ANEG_BIT];
  assign speedSelect100 = st_reg.basicCtrl[strap_pkg::BC_SPEED_BIT];
  assign fullDuplex = st_reg.basicCtrl[strap_pkg::BC_DUPLEX_BIT];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence seqSampleEdge;
    st_reg.state == strap_pkg::CAP_SAMPLE;
  endsequence

  sequence seqReleased;
    seqSampleEdge ##1 1'b1;
  endsequence

  AST_ANEG_LATCH: assert property (
    seqSampleEdge |=> (st_reg.basicCtrl[13:12] ==
      {2{$past(autonegSpeedStrapIn)}}))
    else $error("autoneg strap not latched into control bits");

  AST_ANEG_HIGH: assert property (
    (seqSampleEdge and autonegSpeedStrapIn) |=>
      (autonegEnable && speedSelect100))
    else $error("strap high did not give autoneg at 100");

  AST_ANEG_LOW: assert property (
    (seqSampleEdge and !autonegSpeedStrapIn) |=>
      (!autonegEnable && !speedSelect100))
    else $error("strap low did not give fixed 10");

  AST_ADV_SPEED: assert property (
    seqSampleEdge |=> ((st_reg.advert[8:7] ==
      {2{$past(autonegSpeedStrapIn)}}) && (st_reg.advert[6:5] == 2'b11)))
    else $error("advertised speed does not follow strap");

  AST_ADDR_BIT2: assert property (
    seqSampleEdge |=> (phyAddr[2] == $past(stationAddrStrapIn[1])))
    else $error("address bit 2 not latched");

  AST_ADDR_PAIR_HIGH: assert property (
    (seqSampleEdge and stationAddrStrapIn[0]) |=> (phyAddr[1:0] == 2'b11))
    else $error("low address pair not set");

  AST_ADDR_PAIR_LOW: assert property (
    (seqSampleEdge and !stationAddrStrapIn[0]) |=> (phyAddr[1:0] == 2'b00))
    else $error("low address pair not cleared");

  AST_ADDR_HIGH_ZERO: assert property (
    phyAddr[4:3] == 2'b00)
    else $error("address bits 4 and 3 not zero");

  AST_PIN_RELEASED: assert property (
    seqSampleEdge |-> (!statusLampOe && (stationAddrStrapOe == 2'b00)))
    else $error("strap pin driven before capture");

  AST_PIN_DRIVEN: assert property (
    seqReleased |-> (statusLampOe && (stationAddrStrapOe == 2'b11)))
    else $error("strap pin not driven after capture");

  AST_HOLD: assert property (
    (st_reg.state == strap_pkg::CAP_HOLD) |=>
      ((st_reg.state == strap_pkg::CAP_HOLD) && $stable(phyAddr) &&
       $stable(st_reg.anegStrap)))
    else $error("captured straps changed after release");

  AST_LAMP_NO_LINK: assert property (
    (!linkUp && !st_reg.lampMode[1]) |=> statusLampOut)
    else $error("lamp lit without link");

  AST_LAMP_LINK_ONLY: assert property (
    (linkUp && (st_reg.lampMode == strap_pkg::LAMP_MODE_LINK)) |=>
      !statusLampOut)
    else $error("lamp dark with link in link mode");

  AST_LAMP_STEADY: assert property (
    (linkUp && !activity &&
     (st_reg.lampMode == strap_pkg::LAMP_MODE_LINK_ACT)) |=>
      !statusLampOut)
    else $error("lamp dark with idle link");

  AST_ACK_ONE_CYCLE: assert property (
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
    else $error("bus answer not a single cycle after request");

  AST_ACK_NEEDS_REQ: assert property (
    !(cyc_i && stb_i) |=> !ack_o)
    else $error("bus answer without a request");

  AST_RD_UPPER_ZERO: assert property (
    ack_o |-> (dat_o[31:16] == 16'h0000))
    else $error("upper read half not zero");

  AST_ADV_SELECTOR: assert property (
    st_reg.advert[4:0] == strap_pkg::ADV_SELECTOR)
    else $error("advertised selector field changed");

  AST_LAMP_RESERVED: assert property (
    st_reg.lampMode[1] |=> statusLampOut)
    else $error("lamp lit in a reserved mode");

  AST_PIN_HELD: assert property (
    (st_reg.state == strap_pkg::CAP_HOLD) |->
      (statusLampOe && (stationAddrStrapOe == 2'b11)))
    else $error("strap pin released after capture");

  sequence seqSoftRestore;
    cyc_i && stb_i && we_i && ack_o && sel_i[1] &&
      (adr_i[7:2] == strap_pkg::IDX_BASIC_CTRL[5:0]) &&
      dat_i[strap_pkg::BC_SOFT_RST_BIT] &&
      (st_reg.state == strap_pkg::CAP_HOLD);
  endsequence

  AST_SOFT_RESTORE: assert property (
    seqSoftRestore |=> ((autonegEnable == $past(st_reg.anegStrap)) &&
      (speedSelect100 == $past(st_reg.anegStrap))))
    else $error("soft restore lost the strapped mode");

  AST_PIN_FUNC: assert property (
    (st_reg.state == strap_pkg::CAP_HOLD) |=>
      (stationAddrStrapOut == $past(addrPinFunc)))
    else $error("address pins do not carry their function");

endmodule
`default_nettype wire

// ---- sim/strap_board.sv ----
`timescale 1ns/100ps
`default_nettype none
module strap_board (
  input wire logic pullAneg,
  input wire logic [1:0] pullAddr,
  input wire logic lampDrv,
  input wire logic lampOe,
  input wire logic [1:0] addrDrv,
  input wire logic [1:0] addrOe,
  output logic anegPin,
  output logic [1:0] addrPin,
  output logic lampOn
);
  // ----------------------------------------------------------------
  // resistors win only while the device lets go of a pin
  // ----------------------------------------------------------------
  assign anegPin = lampOe ? lampDrv : pullAneg;
  assign addrPin[0] = addrOe[0] ? addrDrv[0] : pullAddr[0];
  assign addrPin[1] = addrOe[1] ? addrDrv[1] : pullAddr[1];
  // lamp sinks current, so lit while driven low
  assign lampOn = lampOe & ~anegPin;
endmodule
`default_nettype wire

// ---- sim/strap_latch_and_led_control_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); \
  end \
end
module strap_latch_and_led_control_bench;
  logic ref_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, linkUp = 0, activity = 0, lampOut, lampOe, anegPin, lampOn;
  logic pullAneg = 1;
  logic [1:0] pullAddr = 2'h0, addrPin, pinFunc = 2'h0, addrOut, addrOe;
  logic [4:0] phyAddr;
  logic aneg, spd, dup;
  int err_count = 0, comparisons = 0;

  initial forever #2 ref_clk = ~ref_clk;

  strap_latch_and_led_control #(.BLINK_CYCLES(4)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .linkUp(linkUp), .activity(activity),
    .autonegSpeedStrapIn(anegPin), .statusLampOut(lampOut),
    .statusLampOe(lampOe), .stationAddrStrapIn(addrPin),
    .addrPinFunc(pinFunc), .stationAddrStrapOut(addrOut),
    .stationAddrStrapOe(addrOe), .phyAddr(phyAddr),
    .autonegEnable(aneg), .speedSelect100(spd), .fullDuplex(dup));

  strap_board board_u (
    .pullAneg(pullAneg), .pullAddr(pullAddr), .lampDrv(lampOut),
    .lampOe(lampOe), .addrDrv(addrOut), .addrOe(addrOe),
    .anegPin(anegPin), .addrPin(addrPin), .lampOn(lampOn));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // classic single wishbone cycle; ack sampled at the rising edge
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [3:0] s, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      err_count++;
      complete_run();
    end else begin
      // write lands and read data is taken at this same edge
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask

  task automatic count_toggles(output int t);
    logic last;
    t = 0;
    @(negedge ref_clk);
    last = lampOn;
    repeat (40) begin
      @(negedge ref_clk);
      if (lampOn !== last) t++;
      last = lampOn;
    end
  endtask

  initial begin
    int t;
    logic a;
    logic [31:0] ctrlExp, advExp, statExp;
    // ----------------------------------------------------------------
    // strap capture for all four address pull pairs, autoneg pull the inverse of address bit 0
    // ----------------------------------------------------------------
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      rst_n <= 1'b0;
      a = ~i[0];
      pullAneg <= a;
      pullAddr <= i[1:0];
      pinFunc <= i[1:0];
      repeat (20) @(posedge ref_clk);
      `CHK("lamp oe in reset", 1'b0, lampOe)
      `CHK("addr oe in reset", 2'h0, addrOe)
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK("phy addr", {2'b00, i[1], i[0], i[0]}, phyAddr)
      `CHK("aneg", a, aneg)
      `CHK("speed", a, spd)
      `CHK("addr oe", 2'h3, addrOe)
      ctrlExp = a ? 32'h0000_3100 : 32'h0000_0100;
      advExp = a ? 32'h0000_01e1 : 32'h0000_0061;
      wb(1'b0, strap_pkg::ADDR_BASIC_CTRL, 4'h3, 32'h0, q);
      `CHK("ctrl", ctrlExp, q)
      wb(1'b0, strap_pkg::ADDR_ADVERT, 4'h3, 32'h0, q);
      `CHK("advert", advExp, q)
      `CHK("duplex", 1'b1, dup)
      // done, lamp dark, no link, strap level, captured address
      statExp = {23'h0, 3'b110, a, 2'b00, i[1], i[0], i[0]};
      wb(1'b0, strap_pkg::ADDR_STRAP_STAT, 4'h3, 32'h0, q);
      `CHK("strap stat", statExp, q)
      // pins now carry their normal function; capture must not follow
      pinFunc <= ~i[1:0];
      pullAddr <= ~i[1:0];
      pullAneg <= ~a;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK("pin func", ~i[1:0], addrOut)
      `CHK("addr hold", {2'b00, i[1], i[0], i[0]}, phyAddr)
      `CHK("aneg hold", a, aneg)
      `CHK("high addr zero", 2'h0, phyAddr[4:3])
    end
    $display("test straps done");
    // ----------------------------------------------------------------
    // control writes, soft restore, unmapped place
    // ----------------------------------------------------------------
    wb(1'b1, strap_pkg::ADDR_BASIC_CTRL, 4'h3, 32'h0000_3000, q);
    wb(1'b0, strap_pkg::ADDR_BASIC_CTRL, 4'h3, 32'h0, q);
    `CHK("ctrl write", 32'h0000_3000, q)
    wb(1'b1, strap_pkg::ADDR_BASIC_CTRL, 4'h3, 32'h0000_8000, q);
    wb(1'b0, strap_pkg::ADDR_BASIC_CTRL, 4'h3, 32'h0, q);
    `CHK("restore", 32'h0000_0000, q & 32'h0000_b000)
    wb(1'b1, 8'h20, 4'h3, 32'h0000_ffff, q);
    wb(1'b0, 8'h20, 4'h3, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    wb(1'b1, strap_pkg::ADDR_ADVERT, 4'h3, 32'h0000_ffff, q);
    wb(1'b0, strap_pkg::ADDR_ADVERT, 4'h3, 32'h0, q);
    `CHK("advert write", 32'h0000_01e1, q)
    $display("test registers done");
    // ----------------------------------------------------------------
    // lamp modes
    // ----------------------------------------------------------------
    wb(1'b1, strap_pkg::ADDR_LAMP_CTRL, 4'h2, 32'h0000_0010, q);
    wb(1'b0, strap_pkg::ADDR_LAMP_CTRL, 4'h3, 32'h0, q);
    `CHK("lamp sel", 32'h0, q)
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, strap_pkg::ADDR_LAMP_CTRL, 4'h1, 32'(m << 4), q);
      wb(1'b0, strap_pkg::ADDR_LAMP_CTRL, 4'h3, 32'h0, q);
      `CHK("lamp mode", 32'(m << 4), q)
      @(posedge ref_clk);
      linkUp <= 1'b0;
      activity <= 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK("no link", 1'b0, lampOn)
      @(posedge ref_clk);
      linkUp <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK("link", (m < 2), lampOn)
      @(posedge ref_clk);
      activity <= 1'b1;
      count_toggles(t);
      `CHK("activity", (m == 0), (t >= 8 && t <= 11))
      `CHK("no blink", 1'b1, (m == 0) || (t == 0))
    end
    $display("test lamp done");
    complete_run();
  end
endmodule
`default_nettype wire
